// [pkg/dsrp_pkg.sv]
// shared constants for the dual serial register port
package dsrp_pkg;
  localparam logic [5:0] BUS_ADDR_UPPER   = 6'h35;
  localparam int         BYTE_BITS        = 8;
  localparam int         SPI_HEAD_BITS    = 8;
  localparam int         SUB_INC_BIT      = 7;
  localparam logic [6:0] CTRL4_ADDR       = 7'h23;
  localparam int         THREE_WIRE_BIT   = 0;
  localparam logic [7:0] CTRL4_RESET      = 8'h00;
  localparam int         SPI_RW_POS       = 7;
  localparam int         SPI_INC_POS      = 6;
endpackage

// [pkg/dsrp_sync_if.sv]
// synchronised pin levels shared between the top and its pin synchroniser
`timescale 1ns/100ps
`default_nettype none
interface dsrp_sync_if;
  logic scl;
  logic sda;
  logic cs_n;
  logic sdo;
  modport src (output scl, output sda, output cs_n, output sdo);
  modport dst (input scl, input sda, input cs_n, input sdo);
endinterface
`default_nettype wire

// [design/dsrp_sync.sv]
// two-flop synchroniser for the serial pins
`timescale 1ns/100ps
`default_nettype none
module dsrp_sync (
  input  wire logic   clk_in,
  input  wire logic   sys_rst_in,
  input  wire logic   clk_en_in,
  input  wire logic   scl_in,
  input  wire logic   sda_in,
  input  wire logic   cs_n_in,
  input  wire logic   sdo_in,
  dsrp_sync_if.src    pins
);
  logic [3:0] meta_r;
  logic [3:0] meta_nxt;
  logic [3:0] sync_r;
  logic [3:0] sync_nxt;

  always_comb
  begin
    meta_nxt = meta_r;
    sync_nxt = sync_r;
    if (sys_rst_in)
    begin
      meta_nxt = 4'hF;
      sync_nxt = 4'hF;
    end
    else if (clk_en_in)
    begin
      meta_nxt = {scl_in, sda_in, cs_n_in, sdo_in};
      sync_nxt = meta_r;
    end
  end

  always_ff @(posedge clk_in)
  begin
    meta_r <= meta_nxt;
    sync_r <= sync_nxt;
  end

  assign pins.scl  = sync_r[3];
  assign pins.sda  = sync_r[2];
  assign pins.cs_n = sync_r[1];
  assign pins.sdo  = sync_r[0];
endmodule
`default_nettype wire

// [design/dsrp_top.sv]
// two-wire and spi register port slave on shared pins
//
// What this block does
// [R1] bus address is fixed upper six bits plus strapped data-output level
// [R2] first byte after start is seven address bits and a direction bit
// [R3] every byte gets an acknowledge, held low through the ninth clock high
// [R4] pointer byte: low seven bits register address, top bit auto-increment
// [R5] with auto-increment set, address advances after each data byte
// [R6] master reads via pointer write, repeated start, read-direction address
// [R7] master writes pointer then data bytes, ending with stop
// [R8] bytes move most significant bit first, any count per transfer
// [R9] receiver may hold the clock low to stall the transmitter; this block stalls only as read transmitter, in ack slot
// [R10] busy device leaves data high in the address acknowledge slot
// [R11] start and stop are data edges while clock is high
// [R12] spi master holds select low over transaction, clock parked high
// [R13] spi data changes on falling clock edge, sampled on rising edge
// [R14] spi access is sixteen clocks plus eight per extra byte
// [R15] first spi frame bit selects write (0) or read (1)
// [R16] spi read drives output from frame bit eight, msb first
// [R17] second spi frame bit enables per-block address increment
// [R18] spi frame bits two to seven carry the six-bit register index
// [R19] three-wire select bit in control register four selects 3-wire mode
// [R20] in 3-wire mode read data goes out on the shared data pin
// [R21] select high means two-wire slave, low means spi slave
// [R22] unmatched address: stay off the data line until next start or stop
`timescale 1ns/100ps
`default_nettype none
module dsrp_top (
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       clk_en_in,
  input  wire logic       port_shift_clock_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  input  wire logic       sdo_in,
  output logic            sdo_out,
  output logic            sdo_oe_out,
  output logic            scl_out,
  output logic            scl_oe_out,
  input  wire logic       cs_n_in,
  input  wire logic       busy_in,
  output logic [6:0]      reg_addr_out,
  output logic            reg_wr_out,
  output logic [7:0]      reg_wdata_out,
  output logic            reg_rd_out,
  input  wire logic [7:0] reg_rdata_in,
  input  wire logic       rd_ready_in,
  output logic            three_wire_select_out,
  output logic            bus_active_out
);
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_SUB  = 7'h04,
    ST_WDAT = 7'h08,
    ST_RDAT = 7'h10,
    ST_SPI  = 7'h20,
    ST_IGN  = 7'h40
  } dsrp_state_type;

  dsrp_sync_if sp ();

  dsrp_sync u_sync (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .clk_en_in  (clk_en_in),
    .scl_in     (port_shift_clock_in),
    .sda_in     (sda_in),
    .cs_n_in    (cs_n_in),
    .sdo_in     (sdo_in),
    .pins       (sp)
  );

  dsrp_state_type state_r, state_nxt;
  logic       scl_d_r, scl_d_nxt;
  logic       sda_d_r, sda_d_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [7:0] tx_r, tx_nxt;
  logic       ack_r, ack_nxt;
  logic       rd_dir_r, rd_dir_nxt;
  logic       inc_r, inc_nxt;
  logic       mack_r, mack_nxt;
  logic       stall_r, stall_nxt;
  logic [6:0] addr_r, addr_nxt;
  logic       wr_r, wr_nxt;
  logic       rd_r, rd_nxt;
  logic [7:0] wdat_r, wdat_nxt;
  logic [7:0] ctrl4_r, ctrl4_nxt;
  logic       drv_r, drv_nxt;
  logic       spi_rw_r, spi_rw_nxt;
  logic [5:0] spi_cnt_r, spi_cnt_nxt;
  logic       strap_r, strap_nxt;
  logic       sda_o_r, sda_o_nxt;
  logic       sdo_o_r, sdo_o_nxt;

  logic rise, fall, start_c, stop_c, spi_sel;
  logic [7:0] shifted;
  logic [7:0] last_byte;

  assign rise    = sp.scl & ~scl_d_r;
  assign fall    = ~sp.scl & scl_d_r;
  assign start_c = sp.cs_n & sp.scl & scl_d_r & sda_d_r & ~sp.sda;   // R11
  assign stop_c  = sp.cs_n & sp.scl & scl_d_r & ~sda_d_r & sp.sda;   // R11
  assign spi_sel = ~sp.cs_n;                                           // R21
  assign shifted = {sh_r[6:0], sp.sda};                                // R8
  assign last_byte = 8'hFF;

  always_comb
  begin
    state_nxt   = state_r;
    scl_d_nxt   = sp.scl;
    sda_d_nxt   = sp.sda;
    bit_nxt     = bit_r;
    sh_nxt      = sh_r;
    tx_nxt      = tx_r;
    ack_nxt     = ack_r;
    rd_dir_nxt  = rd_dir_r;
    inc_nxt     = inc_r;
    mack_nxt    = mack_r;
    stall_nxt   = stall_r;
    addr_nxt    = addr_r;
    wr_nxt      = 1'b0;
    rd_nxt      = 1'b0;
    wdat_nxt    = wdat_r;
    ctrl4_nxt   = ctrl4_r;
    drv_nxt     = drv_r;
    spi_rw_nxt  = spi_rw_r;
    spi_cnt_nxt = spi_cnt_r;
    strap_nxt   = strap_r;
    if (state_r == ST_IDLE && !spi_sel)
      strap_nxt = sp.sdo;                                              // R1
    // writes to our own control register four are snooped here
    if (wr_r && addr_r == dsrp_pkg::CTRL4_ADDR)
      ctrl4_nxt = wdat_r;                                              // R19
    if (spi_sel && state_r != ST_SPI)
    begin
      state_nxt   = ST_SPI;
      spi_cnt_nxt = 6'h00;
      ack_nxt     = 1'b0;
      drv_nxt     = 1'b0;
    end
    else if (!spi_sel && state_r == ST_SPI)
    begin
      state_nxt = ST_IDLE;                                             // R12
      drv_nxt   = 1'b0;
    end
    else if (start_c)
    begin
      state_nxt = ST_ADDR;                                             // R11
      bit_nxt   = 4'h0;
      ack_nxt   = 1'b0;
      drv_nxt   = 1'b0;
    end
    else if (stop_c)
    begin
      state_nxt = ST_IDLE;                                             // R11
      ack_nxt   = 1'b0;
      drv_nxt   = 1'b0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE, ST_IGN:
        begin
          drv_nxt = 1'b0;                                              // R22
        end
        ST_SPI:
        begin
          if (rise)                                                    // R13
          begin
            sh_nxt      = {sh_r[6:0], sp.sda};
            spi_cnt_nxt = (spi_cnt_r == 6'd15) ? 6'd8 : spi_cnt_r + 6'd1; // R14
            if (spi_cnt_r == 6'd7)
            begin
              spi_rw_nxt = shifted[dsrp_pkg::SPI_RW_POS];              // R15
              inc_nxt    = shifted[dsrp_pkg::SPI_INC_POS];             // R17
              addr_nxt   = {1'b0, shifted[5:0]};                       // R18
              rd_nxt     = shifted[dsrp_pkg::SPI_RW_POS];
            end
            if (spi_cnt_r == 6'd15)
            begin
              if (!spi_rw_r)
              begin
                wr_nxt   = 1'b1;
                wdat_nxt = shifted;
              end
              if (inc_r && spi_rw_r)
                addr_nxt = addr_r + 7'd1;                              // R17
              rd_nxt = spi_rw_r;
            end
          end
          if (rd_r)
            tx_nxt = reg_rdata_in;
          // writes step the address only after the strobe has used it
          if (wr_r && inc_r)
            addr_nxt = addr_r + 7'd1;                                  // R17
          if (fall && spi_rw_r && spi_cnt_r >= 6'd8)                   // R16
          begin
            drv_nxt = 1'b1;
            // block's first bit is already on the pin
            if (spi_cnt_r != 6'd8)
              tx_nxt = {tx_r[6:0], 1'b0};
          end
        end
        ST_ADDR, ST_SUB, ST_WDAT, ST_RDAT:
        begin
          if (rd_r)
            tx_nxt = reg_rdata_in;
          // stall the master by holding the clock low until data is ready
          stall_nxt = ack_r && state_r == ST_RDAT && !rd_ready_in;     // R9
          if (rise && !ack_r && !(state_r == ST_RDAT))
          begin
            sh_nxt  = shifted;
            bit_nxt = bit_r + 4'h1;
          end
          if (rise && ack_r && state_r == ST_RDAT && drv_r == 1'b0)
            mack_nxt = sp.sda;                                         // R6
          if (rise && !ack_r && state_r == ST_RDAT)
            bit_nxt = bit_r + 4'h1;
          if (fall)
          begin
            if (!ack_r && bit_r == 4'd8)
            begin
              bit_nxt = 4'h0;
              ack_nxt = 1'b1;                                          // R3
              if (state_r == ST_ADDR)
              begin
                if (sh_r[7:1] != {dsrp_pkg::BUS_ADDR_UPPER, strap_r})  // R2
                begin
                  state_nxt = ST_IGN;                                  // R22
                  ack_nxt   = 1'b0;
                end
                else if (busy_in)
                begin
                  state_nxt = ST_IGN;                                  // R10
                  ack_nxt   = 1'b0;
                end
                else
                begin
                  rd_dir_nxt = sh_r[0];
                  drv_nxt    = 1'b1;
                end
              end
              else if (state_r == ST_RDAT)
                drv_nxt = 1'b0;
              else
                drv_nxt = 1'b1;
              if (state_r == ST_SUB)
              begin
                addr_nxt = sh_r[6:0];                                  // R4
                inc_nxt  = sh_r[dsrp_pkg::SUB_INC_BIT];
              end
              if (state_r == ST_WDAT)
              begin
                wr_nxt   = 1'b1;                                       // R7
                wdat_nxt = sh_r;
              end
            end
            else if (ack_r)
            begin
              ack_nxt = 1'b0;
              drv_nxt = 1'b0;
              if (state_r == ST_ADDR)
              begin
                state_nxt = rd_dir_r ? ST_RDAT : ST_SUB;
                rd_nxt    = rd_dir_r;
              end
              else if (state_r == ST_SUB)
                state_nxt = ST_WDAT;
              else if (state_r == ST_WDAT)
              begin
                if (inc_r)
                  addr_nxt = addr_r + 7'd1;                            // R5
              end
              else if (mack_r)
                state_nxt = ST_IGN;                                    // R6
              else
              begin
                if (inc_r)
                  addr_nxt = addr_r + 7'd1;                            // R5
                rd_nxt = 1'b1;
              end
              if (state_nxt == ST_RDAT)
                drv_nxt = 1'b1;
            end
            else if (state_r == ST_RDAT)
            begin
              drv_nxt = 1'b1;
              if (bit_r != 4'd0)
                tx_nxt = {tx_r[6:0], 1'b0};                            // R8
            end
          end
        end
        default:
          state_nxt = ST_IDLE;
      endcase
    end
  end

  // the data pin level is picked from whichever slave owns the pins
  always_comb
  begin
    sda_o_nxt = 1'b1;
    sdo_o_nxt = 1'b1;
    if (state_r == ST_SPI)
    begin
      sdo_o_nxt = tx_r[7];                                             // R16
      sda_o_nxt = tx_r[7];                                             // R20
    end
    else if (state_r == ST_RDAT && !ack_r)
      sda_o_nxt = tx_r[7];
    else if (ack_r)
      sda_o_nxt = 1'b0;                                                // R3
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      state_r   <= ST_IDLE;
      scl_d_r   <= 1'b1;
      sda_d_r   <= 1'b1;
      bit_r     <= 4'h0;
      sh_r      <= 8'h00;
      tx_r      <= 8'hFF;
      ack_r     <= 1'b0;
      rd_dir_r  <= 1'b0;
      inc_r     <= 1'b0;
      mack_r    <= 1'b0;
      stall_r   <= 1'b0;
      addr_r    <= 7'h00;
      wr_r      <= 1'b0;
      rd_r      <= 1'b0;
      wdat_r    <= 8'h00;
      ctrl4_r   <= dsrp_pkg::CTRL4_RESET;
      drv_r     <= 1'b0;
      spi_rw_r  <= 1'b0;
      spi_cnt_r <= 6'h00;
      strap_r   <= 1'b0;
      sda_o_r   <= 1'b1;
      sdo_o_r   <= 1'b1;
    end
    else if (clk_en_in)
    begin
      state_r   <= state_nxt;
      scl_d_r   <= scl_d_nxt;
      sda_d_r   <= sda_d_nxt;
      bit_r     <= bit_nxt;
      sh_r      <= sh_nxt;
      tx_r      <= tx_nxt;
      ack_r     <= ack_nxt;
      rd_dir_r  <= rd_dir_nxt;
      inc_r     <= inc_nxt;
      mack_r    <= mack_nxt;
      stall_r   <= stall_nxt;
      addr_r    <= addr_nxt;
      wr_r      <= wr_nxt;
      rd_r      <= rd_nxt;
      wdat_r    <= wdat_nxt;
      ctrl4_r   <= ctrl4_nxt;
      drv_r     <= drv_nxt;
      spi_rw_r  <= spi_rw_nxt;
      spi_cnt_r <= spi_cnt_nxt;
      strap_r   <= strap_nxt;
      sda_o_r   <= sda_o_nxt;
      sdo_o_r   <= sdo_o_nxt;
    end
  end

  assign three_wire_select_out = ctrl4_r[dsrp_pkg::THREE_WIRE_BIT];
  assign sda_out        = sda_o_r;
  assign sda_oe_out     = drv_r & ((state_r != ST_SPI) | three_wire_select_out); // R20
  assign sdo_out        = sdo_o_r;
  assign sdo_oe_out     = drv_r & (state_r == ST_SPI) & ~three_wire_select_out;
  assign scl_out        = 1'b0;
  assign scl_oe_out     = stall_r;                                      // R9
  assign reg_addr_out   = addr_r;
  assign reg_wr_out     = wr_r;
  assign reg_wdata_out  = wdat_r;
  assign reg_rd_out     = rd_r;
  assign bus_active_out = (state_r != ST_IDLE);
endmodule
`default_nettype wire

// [bench/dsrp_properties.sv]
// assertion checker bound to the register port top
`timescale 1ns/100ps
`default_nettype none
module dsrp_properties (
  input wire logic       clk_in,
  input wire logic       sys_rst_in,
  input wire logic       cs_n_in,
  input wire logic       sda_oe_out,
  input wire logic       sdo_oe_out,
  input wire logic       scl_out,
  input wire logic       scl_oe_out,
  input wire logic [6:0] reg_addr_out,
  input wire logic       reg_wr_out,
  input wire logic       reg_rd_out,
  input wire logic       three_wire_select_out,
  input wire logic       bus_active_out
);
  localparam logic [6:0] CTRL4 = dsrp_pkg::CTRL4_ADDR;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  // six cycles cover synchroniser and edge detect
  property p_sdo_idle;
    cs_n_in [*6] |-> !sdo_oe_out;
  endproperty
  a_sdo_idle: assert property (p_sdo_idle)
    else $error("sdo driven in two-wire mode");
  property p_sda_idle_4w;
    !cs_n_in [*6] ##0 !three_wire_select_out |-> !sda_oe_out;
  endproperty
  a_sda_idle_4w: assert property (p_sda_idle_4w)
    else $error("sda driven in 4-wire mode");
  property p_no_stretch_spi;
    !cs_n_in [*6] |-> !scl_oe_out;
  endproperty
  a_no_stretch_spi: assert property (p_no_stretch_spi)
    else $error("clock held in spi mode");
  property p_stretch_low;
    scl_oe_out |-> !scl_out;
  endproperty
  a_stretch_low: assert property (p_stretch_low)
    else $error("clock stretch not low");
  property p_drive_active;
    $rose(sda_oe_out) |-> bus_active_out;
  endproperty
  a_drive_active: assert property (p_drive_active)
    else $error("sda driven while idle");
  property p_wr_pulse;
    reg_wr_out |=> !reg_wr_out;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("write strobe too long");
  property p_rd_pulse;
    reg_rd_out |=> !reg_rd_out;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse)
    else $error("read strobe too long");
  property p_ctrl4;
    $changed(three_wire_select_out) |-> (reg_wr_out || $past(reg_wr_out))
      && (reg_addr_out == CTRL4 || $past(reg_addr_out) == CTRL4);
  endproperty
  a_ctrl4: assert property (p_ctrl4)
    else $error("mode bit moved without write");
endmodule
bind dsrp_top dsrp_properties u_props (
  .clk_in, .sys_rst_in, .cs_n_in, .sda_oe_out, .sdo_oe_out, .scl_out,
  .scl_oe_out, .reg_addr_out, .reg_wr_out, .reg_rd_out,
  .three_wire_select_out, .bus_active_out
);
`default_nettype wire

// [bench/dsrp_host_model.sv]
// behavioural host master for two-wire and spi
`timescale 1ns/100ps
`default_nettype none
module dsrp_host_model (
  input  wire logic dev_sda_in,
  input  wire logic dev_sda_oe_in,
  input  wire logic dev_sdo_in,
  input  wire logic dev_sdo_oe_in,
  input  wire logic dev_scl_in,
  input  wire logic dev_scl_oe_in,
  input  wire logic strap_in,
  output logic      scl_out,
  output logic      sda_out,
  output logic      sdo_out,
  output logic      cs_n_out
);
  logic scl_m = 1'b1;
  logic sda_m = 1'b1;
  logic cs_m  = 1'b1;
  // pulled-up lines: any party may pull low
  assign scl_out  = scl_m & ~(dev_scl_oe_in & ~dev_scl_in);
  assign sda_out  = sda_m & ~(dev_sda_oe_in & ~dev_sda_in);
  assign sdo_out  = dev_sdo_oe_in ? dev_sdo_in : strap_in;
  assign cs_n_out = cs_m;
  task automatic tick(output logic s);
    #20 scl_m = 1'b1;
    for (int i = 0; i < 200 && !scl_out; i++)
      #5;
    #20 s = sda_out;
    #20 scl_m = 1'b0;
    #20;
  endtask
  task automatic start();
    sda_m = 1'b1;
    #20 scl_m = 1'b1;
    #40 sda_m = 1'b0;
    #40 scl_m = 1'b0;
    #20;
  endtask
  task automatic stop();
    sda_m = 1'b0;
    #20 scl_m = 1'b1;
    #40 sda_m = 1'b1;
    #40;
  endtask
  task automatic byte_w(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      sda_m = b[i];
      tick(s);
    end
    sda_m = 1'b1;
    tick(s);
    ack = !s;
  endtask
  task automatic byte_r(input logic mack, output logic [7:0] d);
    logic s;
    sda_m = 1'b1;
    for (int i = 7; i >= 0; i--)
      tick(d[i]);
    sda_m = !mack;
    tick(s);
  endtask
  task automatic spi(input logic [23:0] w, input int n, input logic tw,
                     output logic [7:0] r);
    cs_m = 1'b0;
    #40;
    for (int i = n - 1; i >= 0; i--)
    begin
      scl_m = 1'b0;
      sda_m = w[i];
      #40 scl_m = 1'b1;
      r = {r[6:0], tw ? sda_out : sdo_out};
      #40;
    end
    cs_m  = 1'b1;
    sda_m = 1'b1;
    #80;
  endtask
endmodule
`default_nettype wire

// [bench/dsrp_top_tb.sv]
// self-checking bench for the dual serial register port
`timescale 1ns/100ps
`default_nettype none
module dsrp_top_tb;
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        clk_en_in = 1'b1;
  logic        busy_in = 1'b0;
  logic        rd_ready_in = 1'b1;
  logic        strap = 1'b0;
  logic [7:0]  reg_rdata_in = 8'h00;
  wire         scl, sda, sdo, cs_n_in;
  logic        sda_out, sda_oe_out, sdo_out, sdo_oe_out, scl_out, scl_oe_out;
  logic        reg_wr_out, reg_rd_out, three_wire_select_out, bus_active_out;
  logic [6:0]  reg_addr_out;
  logic [7:0]  reg_wdata_out, d;
  logic        a;
  logic        stall_seen = 1'b0;
  logic [14:0] wq[$];
  int          mismatches = 0;
  int          checks_done = 0;
  dsrp_top uut (.clk_in, .sys_rst_in, .clk_en_in, .port_shift_clock_in(scl),
    .sda_in(sda), .sda_out, .sda_oe_out, .sdo_in(sdo), .sdo_out, .sdo_oe_out,
    .scl_out, .scl_oe_out, .cs_n_in, .busy_in, .reg_addr_out, .reg_wr_out,
    .reg_wdata_out, .reg_rd_out, .reg_rdata_in, .rd_ready_in,
    .three_wire_select_out, .bus_active_out);
  dsrp_host_model host (.dev_sda_in(sda_out), .dev_sda_oe_in(sda_oe_out),
    .dev_sdo_in(sdo_out), .dev_sdo_oe_in(sdo_oe_out), .dev_scl_in(scl_out),
    .dev_scl_oe_in(scl_oe_out), .strap_in(strap), .scl_out(scl),
    .sda_out(sda), .sdo_out(sdo), .cs_n_out(cs_n_in));
  initial
    forever #2.5 clk_in = ~clk_in;
  // read data derived from the address so bursts are distinguishable
  always @(negedge clk_in)
    reg_rdata_in <= {1'b0, reg_addr_out} ^ 8'h3C;
  always @(posedge clk_in)
    if (reg_wr_out === 1'b1)
      wq.push_back({reg_addr_out, reg_wdata_out});
  always @(posedge clk_in)
    if (scl_oe_out === 1'b1)
      stall_seen <= 1'b1;
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wchk(input logic [14:0] e);
    logic [14:0] g;
    g = 'x;
    #200;
    if (wq.size() > 0)
      g = wq.pop_front();
    chk("write", {1'b0, e}, {1'b0, g});
  endtask
  task automatic t_i2c_write();
    host.start();
    host.byte_w(8'hD4, a);
    chk("addr ack", 1, a);
    host.byte_w(8'hA2, a);
    chk("sub ack", 1, a);
    host.byte_w(8'h5A, a);
    chk("data ack", 1, a);
    host.byte_w(8'h01, a);
    host.stop();
    wchk({7'h22, 8'h5A});
    wchk({7'h23, 8'h01});
    chk("three wire", 1, three_wire_select_out);
    $display("i2c write done");
  endtask
  task automatic t_i2c_refuse();
    host.start();
    host.byte_w(8'hD6, a);
    chk("wrong addr", 0, a);
    host.byte_w(8'h20, a);
    chk("ignored", 0, a);
    host.stop();
    @(negedge clk_in) busy_in = 1'b1;
    host.start();
    host.byte_w(8'hD4, a);
    chk("busy", 0, a);
    host.stop();
    @(negedge clk_in) busy_in = 1'b0;
    #200 chk("no write", 0, wq.size());
    $display("i2c refuse done");
  endtask
  task automatic t_i2c_read();
    @(negedge clk_in) strap = 1'b1;
    #400 host.start();
    host.byte_w(8'hD6, a);
    chk("strap addr", 1, a);
    host.byte_w(8'h90, a);
    @(negedge clk_in) rd_ready_in = 1'b0;
    // held off until the first master acknowledge slot so the clock stalls
    fork
      begin
        #1800;
        @(negedge clk_in) rd_ready_in = 1'b1;
      end
    join_none
    host.start();
    host.byte_w(8'hD7, a);
    chk("read ack", 1, a);
    host.byte_r(1'b1, d);
    chk("stall", 1, stall_seen);
    chk("read0", 8'h10 ^ 8'h3C, d);
    host.byte_r(1'b0, d);
    chk("read1", 8'h11 ^ 8'h3C, d);
    host.stop();
    $display("i2c read done");
  endtask
  task automatic t_spi();
    host.spi({8'h00, 2'b10, 6'h05, 8'hFF}, 16, 1'b1, d);
    chk("3w read", 8'h05 ^ 8'h3C, d);
    host.spi({8'h00, 2'b00, 6'h23, 8'h00}, 16, 1'b0, d);
    wchk({7'h23, 8'h00});
    chk("four wire", 0, three_wire_select_out);
    host.spi({2'b01, 6'h20, 16'h1122}, 24, 1'b0, d);
    wchk({7'h20, 8'h11});
    wchk({7'h21, 8'h22});
    host.spi({2'b00, 6'h30, 16'h3344}, 24, 1'b0, d);
    wchk({7'h30, 8'h33});
    wchk({7'h30, 8'h44});
    host.spi({2'b11, 6'h06, 16'hFFFF}, 24, 1'b0, d);
    chk("4w read", 8'h07 ^ 8'h3C, d);
    $display("spi done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #200000;
    mismatches++;
    end_of_test();
  end
  initial
  begin
    repeat (2) @(posedge clk_in);
    @(negedge clk_in) sys_rst_in = 1'b0;
    repeat (8) @(negedge clk_in);
    t_i2c_write();
    t_spi_pre();
    end_of_test();
  end
  task automatic t_spi_pre();
    t_i2c_refuse();
    t_spi();
    t_i2c_read();
  endtask
endmodule
`default_nettype wire
